// ---- core/cond_pkg.sv ----
// constants, codes and register map of the condition flag block
// Notes on behaviour
// - one of sixteen conditions is chosen per microinstruction by a 4-bit select field.
// - the chosen condition may be tested for zero or one; result steers the successor.
// - six resettable flags: two global, three local, one counter overflow.
// - global flags change only through the adjust field and the software and system clears; testing leaves them alone.
// - local flags are set by the adjust field and cleared when tested.
// - overflow flag sets when a counter increment finds the counter at all ones.
// - overflow flag clears when tested or when the counter is loaded.
// - a set and a clear of the overflow flag together leave it cleared.
// - testing overflow looks at the stored flag OR the live counter overflow.
// - the overflow test clear is gated by inverted nanobit 48 and the select decode.
// - flag select codes: 0 g1, 1 g2, 2 l1, 3 l2, d l3, 8 overflow.
// - set and tested together: global and local end set, overflow ends cleared.
// - adjust actions take effect at the end of phase 1.
// - adjust codes: 0 none, 1 set l2, 2 set g2, 3 clear g2, 4 set l3, 5 clr g1, 6 set g1, 7 set l1.
// - external select codes: 9, a, b, c, e and f as listed.
// - write buffer ready and read done always present their asserted low level.
// - codes 4 to 7 pick adder top bit, bottom bit, all ones, carry; never cleared.
// - successor is one when the selected condition equals the polarity bit.
// - side effect bit 0 adjusts always; 1 adjusts only when the successor is one.
package cond_pkg;

  localparam int SEL_W = 4;
  localparam int ADJ_W = 3;
  localparam int NFLAG = 6;
  localparam int NEXT = 6;
  localparam int NADD = 4;

  // flag positions in the condition register
  localparam int F_G1 = 0;
  localparam int F_G2 = 1;
  localparam int F_L1 = 2;
  localparam int F_L2 = 3;
  localparam int F_L3 = 4;
  localparam int F_OVF = 5;

  // external line positions
  localparam int X_ANY_REQ = 0;
  localparam int X_TIMER = 1;
  localparam int X_DATA_REQ = 2;
  localparam int X_STATUS_REQ = 3;

  // adder condition positions
  localparam int A_TOP = 0;
  localparam int A_BOTTOM = 1;
  localparam int A_ONES = 2;
  localparam int A_CARRY = 3;

  // level of the always-asserted memory lines (active low)
  localparam logic LINE_ASSERTED = 1'b0;

  typedef enum logic [3:0] {
    SEL_GLOBAL_ONE = 4'h0,
    SEL_GLOBAL_TWO = 4'h1,
    SEL_LOCAL_ONE = 4'h2,
    SEL_LOCAL_TWO = 4'h3,
    SEL_ADDER_TOP = 4'h4,
    SEL_ADDER_BOTTOM = 4'h5,
    SEL_ADDER_ONES = 4'h6,
    SEL_ADDER_CARRY = 4'h7,
    SEL_COUNTER_OVF = 4'h8,
    SEL_WRITE_BUF_READY = 4'h9,
    SEL_READ_DONE = 4'ha,
    SEL_ANY_PORT_REQ = 4'hb,
    SEL_TIMER_TICK = 4'hc,
    SEL_LOCAL_THREE = 4'hd,
    SEL_PORT_DATA_REQ = 4'he,
    SEL_PORT_STATUS_REQ = 4'hf
  } cond_sel_t;

  typedef enum logic [2:0] {
    ADJ_NONE = 3'h0,
    ADJ_SET_LOCAL_TWO = 3'h1,
    ADJ_SET_GLOBAL_TWO = 3'h2,
    ADJ_CLR_GLOBAL_TWO = 3'h3,
    ADJ_SET_LOCAL_THREE = 3'h4,
    ADJ_CLR_GLOBAL_ONE = 3'h5,
    ADJ_SET_GLOBAL_ONE = 3'h6,
    ADJ_SET_LOCAL_ONE = 3'h7
  } adjust_t;

  // bus register map (byte addresses)
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_CLEAR_BIT = 1;
  localparam logic CTRL_ENABLE_RESET = 1'b1;
  localparam int ST_FLAGS_LSB = 0;
  localparam int ST_SUCC_BIT = 6;
  localparam int ST_ADJ_BIT = 7;
  localparam int ST_COND_BIT = 8;
  localparam int ST_SEL_LSB = 12;

  // bus encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [1:0] HRESP_OKAY = 2'h0;

endpackage

// ---- core/cond_if.sv ----
// signals shared between the condition selector and the top
`timescale 1ns/1ps
interface cond_if;
  logic [cond_pkg::SEL_W-1:0] sel;
  logic polarity;
  logic side_effect;
  logic [cond_pkg::NFLAG-1:0] flags;
  logic live_ovf;
  logic [cond_pkg::NEXT-3:0] req_lines;
  logic [cond_pkg::NADD-1:0] adder;
  logic condition;
  logic successor;
  logic adjust_en;

  modport mux (
    input sel, polarity, side_effect, flags, live_ovf, req_lines, adder,
    output condition, successor, adjust_en
  );
  modport top (
    output sel, polarity, side_effect, flags, live_ovf, req_lines, adder,
    input condition, successor, adjust_en
  );
endinterface

// ---- core/cond_select.sv ----
// sixteen-way condition selector with polarity test and adjust enable
`timescale 1ns/1ps
module cond_select (
  cond_if.mux cif
);
  always_comb begin
    case (cond_pkg::cond_sel_t'(cif.sel))
      cond_pkg::SEL_GLOBAL_ONE: cif.condition = cif.flags[cond_pkg::F_G1];
      cond_pkg::SEL_GLOBAL_TWO: cif.condition = cif.flags[cond_pkg::F_G2];
      cond_pkg::SEL_LOCAL_ONE: cif.condition = cif.flags[cond_pkg::F_L1];
      cond_pkg::SEL_LOCAL_TWO: cif.condition = cif.flags[cond_pkg::F_L2];
      cond_pkg::SEL_ADDER_TOP: cif.condition = cif.adder[cond_pkg::A_TOP];
      cond_pkg::SEL_ADDER_BOTTOM: cif.condition = cif.adder[cond_pkg::A_BOTTOM];
      cond_pkg::SEL_ADDER_ONES: cif.condition = cif.adder[cond_pkg::A_ONES];
      cond_pkg::SEL_ADDER_CARRY: cif.condition = cif.adder[cond_pkg::A_CARRY];
      cond_pkg::SEL_COUNTER_OVF: cif.condition = cif.flags[cond_pkg::F_OVF] | cif.live_ovf;
      cond_pkg::SEL_WRITE_BUF_READY: cif.condition = cond_pkg::LINE_ASSERTED;
      cond_pkg::SEL_READ_DONE: cif.condition = cond_pkg::LINE_ASSERTED;
      cond_pkg::SEL_ANY_PORT_REQ: cif.condition = cif.req_lines[cond_pkg::X_ANY_REQ];
      cond_pkg::SEL_TIMER_TICK: cif.condition = cif.req_lines[cond_pkg::X_TIMER];
      cond_pkg::SEL_LOCAL_THREE: cif.condition = cif.flags[cond_pkg::F_L3];
      cond_pkg::SEL_PORT_DATA_REQ: cif.condition = cif.req_lines[cond_pkg::X_DATA_REQ];
      default: cif.condition = cif.req_lines[cond_pkg::X_STATUS_REQ];
    endcase
    cif.successor = (cif.condition == cif.polarity);
    cif.adjust_en = ~cif.side_effect | cif.successor;
  end
endmodule

// ---- core/flag_update.sv ----
// next value of the six stored condition flags
`timescale 1ns/1ps
module flag_update #(
  parameter int NF = cond_pkg::NFLAG
) (
  // present state and microinstruction
  input wire logic [NF-1:0] flags_i,
  input wire logic step_i,
  input wire logic adjust_en_i,
  input wire logic [cond_pkg::ADJ_W-1:0] adjust_i,
  input wire logic [cond_pkg::SEL_W-1:0] sel_i,
  input wire logic ovf_clear_gate_i,
  // counter and clears
  input wire logic ovf_set_i,
  input wire logic counter_load_i,
  input wire logic sw_clear_i,
  input wire logic system_clear_i,
  // next value
  output logic [NF-1:0] flags_o
);
  logic [NF-1:0] set_v;
  logic [NF-1:0] adj_clr;
  logic [NF-1:0] test_clr;
  always_comb begin
    set_v = '0;
    adj_clr = '0;
    test_clr = '0;
    if (step_i && adjust_en_i) begin
      case (cond_pkg::adjust_t'(adjust_i))
        cond_pkg::ADJ_SET_LOCAL_TWO: set_v[cond_pkg::F_L2] = 1'b1;
        cond_pkg::ADJ_SET_GLOBAL_TWO: set_v[cond_pkg::F_G2] = 1'b1;
        cond_pkg::ADJ_CLR_GLOBAL_TWO: adj_clr[cond_pkg::F_G2] = 1'b1;
        cond_pkg::ADJ_SET_LOCAL_THREE: set_v[cond_pkg::F_L3] = 1'b1;
        cond_pkg::ADJ_CLR_GLOBAL_ONE: adj_clr[cond_pkg::F_G1] = 1'b1;
        cond_pkg::ADJ_SET_GLOBAL_ONE: set_v[cond_pkg::F_G1] = 1'b1;
        cond_pkg::ADJ_SET_LOCAL_ONE: set_v[cond_pkg::F_L1] = 1'b1;
        default: set_v = '0;
      endcase
    end
    if (step_i) begin
      case (cond_pkg::cond_sel_t'(sel_i))
        cond_pkg::SEL_LOCAL_ONE: test_clr[cond_pkg::F_L1] = 1'b1;
        cond_pkg::SEL_LOCAL_TWO: test_clr[cond_pkg::F_L2] = 1'b1;
        cond_pkg::SEL_LOCAL_THREE: test_clr[cond_pkg::F_L3] = 1'b1;
        cond_pkg::SEL_COUNTER_OVF: test_clr[cond_pkg::F_OVF] = ovf_clear_gate_i;
        default: test_clr = '0;
      endcase
    end
    set_v[cond_pkg::F_OVF] = ovf_set_i;
    // sets win over test and software clears on the ordinary flags
    flags_o = (flags_i & ~adj_clr & ~test_clr & ~{NF{sw_clear_i}}) | set_v;
    flags_o[cond_pkg::F_OVF] = flags_o[cond_pkg::F_OVF] & ~(test_clr[cond_pkg::F_OVF] | counter_load_i);
    if (system_clear_i) begin
      flags_o = '0;
    end
  end
endmodule

// ---- core/cond_register.sv ----
// condition register, selector and successor output with an AHB-Lite register window
//
// The AHB-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
module cond_register (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic system_clear_i,
  // microinstruction fields, taken on step_i (end of phase 1)
  input wire logic step_i,
  input wire logic [cond_pkg::SEL_W-1:0] condition_select_field_i,
  input wire logic test_polarity_bit_i,
  input wire logic conditional_side_effect_bit_i,
  input wire logic [cond_pkg::ADJ_W-1:0] flag_adjust_field_i,
  input wire logic nanobit48_i,
  // loop counter
  input wire logic counter_increment_i,
  input wire logic counter_all_ones_i,
  input wire logic counter_live_overflow_i,
  input wire logic counter_load_i,
  // external request lines, raw low-active levels
  input wire logic any_port_request_n_i,
  input wire logic timer_tick_interrupt_n_i,
  input wire logic selected_port_data_request_n_i,
  input wire logic selected_port_status_request_n_i,
  // adder status from the previous microinstruction
  input wire logic adder_top_bit_i,
  input wire logic adder_bottom_bit_i,
  input wire logic adder_all_ones_i,
  input wire logic adder_carry_out_i,
  // results
  output logic successor_select_o,
  output logic selected_condition_o,
  output logic flag_adjust_enable_o,
  output logic [cond_pkg::NFLAG-1:0] flags_o,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o
);

  cond_if cif ();

  logic step;
  logic overflow_clear_gate;
  logic ovf_set;
  logic sw_clear;
  logic [cond_pkg::NFLAG-1:0] flags_q;
  logic [cond_pkg::NFLAG-1:0] flags_d;

  // captured results of the last microinstruction
  logic succ_q;
  logic succ_d;
  logic cond_q;
  logic cond_d;
  logic adj_q;
  logic adj_d;
  logic [cond_pkg::SEL_W-1:0] sel_q;
  logic [cond_pkg::SEL_W-1:0] sel_d;

  // bus state
  logic ctrl_enable_q;
  logic ctrl_enable_d;
  logic ap_valid_q;
  logic ap_valid_d;
  logic ap_write_q;
  logic ap_write_d;
  logic [cond_pkg::ADDR_W-1:0] ap_addr_q;
  logic [cond_pkg::ADDR_W-1:0] ap_addr_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic addr_phase;
  logic wr_ctrl;

  // steps are ignored while software holds the block disabled
  assign step = step_i & ctrl_enable_q;
  assign overflow_clear_gate = ~nanobit48_i;
  assign ovf_set = counter_increment_i & counter_all_ones_i;

  assign cif.sel = condition_select_field_i;
  assign cif.polarity = test_polarity_bit_i;
  assign cif.side_effect = conditional_side_effect_bit_i;
  assign cif.flags = flags_q;
  assign cif.live_ovf = counter_live_overflow_i;
  assign cif.req_lines[cond_pkg::X_ANY_REQ] = any_port_request_n_i;
  assign cif.req_lines[cond_pkg::X_TIMER] = timer_tick_interrupt_n_i;
  assign cif.req_lines[cond_pkg::X_DATA_REQ] = selected_port_data_request_n_i;
  assign cif.req_lines[cond_pkg::X_STATUS_REQ] = selected_port_status_request_n_i;
  assign cif.adder[cond_pkg::A_TOP] = adder_top_bit_i;
  assign cif.adder[cond_pkg::A_BOTTOM] = adder_bottom_bit_i;
  assign cif.adder[cond_pkg::A_ONES] = adder_all_ones_i;
  assign cif.adder[cond_pkg::A_CARRY] = adder_carry_out_i;

  cond_select u_select (
    .cif(cif.mux)
  );

  flag_update #(
    .NF(cond_pkg::NFLAG)
  ) u_update (
    .flags_i(flags_q),
    .step_i(step),
    .adjust_en_i(cif.adjust_en),
    .adjust_i(flag_adjust_field_i),
    .sel_i(condition_select_field_i),
    .ovf_clear_gate_i(overflow_clear_gate),
    .ovf_set_i(ovf_set),
    .counter_load_i(counter_load_i),
    .sw_clear_i(sw_clear),
    .system_clear_i(system_clear_i),
    .flags_o(flags_d)
  );

  // microinstruction results, held until the next step
  always_comb begin
    succ_d = succ_q;
    cond_d = cond_q;
    adj_d = adj_q;
    sel_d = sel_q;
    if (step) begin
      succ_d = cif.successor;
      cond_d = cif.condition;
      adj_d = cif.adjust_en;
      sel_d = condition_select_field_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      flags_q <= '0;
      succ_q <= 1'b0;
      cond_q <= 1'b0;
      adj_q <= 1'b0;
      sel_q <= '0;
    end else begin
      flags_q <= flags_d;
      succ_q <= succ_d;
      cond_q <= cond_d;
      adj_q <= adj_d;
      sel_q <= sel_d;
    end
  end

  // bus: address phase capture, data phase write, read data prepared one cycle ahead
  assign addr_phase = hsel_i & hready_i & htrans_i[1];
  assign wr_ctrl = ap_valid_q & ap_write_q & (ap_addr_q == cond_pkg::ADDR_CTRL);
  assign sw_clear = wr_ctrl & hwdata_i[cond_pkg::CTRL_CLEAR_BIT];

  always_comb begin
    ap_valid_d = ap_valid_q;
    ap_write_d = ap_write_q;
    ap_addr_d = ap_addr_q;
    ctrl_enable_d = ctrl_enable_q;
    rdata_d = rdata_q;
    if (wr_ctrl) begin
      ctrl_enable_d = hwdata_i[cond_pkg::CTRL_ENABLE_BIT];
    end
    if (hready_i) begin
      ap_valid_d = addr_phase & (hsize_i == cond_pkg::HSIZE_WORD);
      ap_write_d = hwrite_i;
      ap_addr_d = haddr_i[cond_pkg::ADDR_W-1:0];
    end
    if (addr_phase && !hwrite_i) begin
      rdata_d = '0;
      if (haddr_i[cond_pkg::ADDR_W-1:0] == cond_pkg::ADDR_CTRL) begin
        rdata_d[cond_pkg::CTRL_ENABLE_BIT] = ctrl_enable_d;
      end else if (haddr_i[cond_pkg::ADDR_W-1:0] == cond_pkg::ADDR_STATUS) begin
        rdata_d[cond_pkg::ST_FLAGS_LSB +: cond_pkg::NFLAG] = flags_q;
        rdata_d[cond_pkg::ST_SUCC_BIT] = succ_q;
        rdata_d[cond_pkg::ST_ADJ_BIT] = adj_q;
        rdata_d[cond_pkg::ST_COND_BIT] = cond_q;
        rdata_d[cond_pkg::ST_SEL_LSB +: cond_pkg::SEL_W] = sel_q;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ap_valid_q <= 1'b0;
      ap_write_q <= 1'b0;
      ap_addr_q <= '0;
      ctrl_enable_q <= cond_pkg::CTRL_ENABLE_RESET;
      rdata_q <= '0;
    end else begin
      ap_valid_q <= ap_valid_d;
      ap_write_q <= ap_write_d;
      ap_addr_q <= ap_addr_d;
      ctrl_enable_q <= ctrl_enable_d;
      rdata_q <= rdata_d;
    end
  end

  // outputs straight from flip-flops; hreadyout_o is low during reset, then the slave never waits and always answers OKAY
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      hreadyout_o <= 1'b0;
      hresp_o <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o <= cond_pkg::HRESP_OKAY[0];
    end
  end

  assign hrdata_o = rdata_q;
  assign successor_select_o = succ_q;
  assign selected_condition_o = cond_q;
  assign flag_adjust_enable_o = adj_q;
  assign flags_o = flags_q;

endmodule

// ---- test/cond_register_monitor.sv ----
// checker on the condition register ports
`timescale 1ns/1ps
module cond_register_monitor (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic system_clear_i,
  // microinstruction and counter
  input wire logic step_i,
  input wire logic [3:0] condition_select_field_i,
  input wire logic test_polarity_bit_i,
  input wire logic conditional_side_effect_bit_i,
  input wire logic [2:0] flag_adjust_field_i,
  input wire logic nanobit48_i,
  input wire logic counter_increment_i,
  input wire logic counter_all_ones_i,
  input wire logic counter_live_overflow_i,
  input wire logic counter_load_i,
  input wire logic adder_top_bit_i,
  input wire logic adder_bottom_bit_i,
  input wire logic adder_all_ones_i,
  input wire logic adder_carry_out_i,
  // results
  input wire logic successor_select_o,
  input wire logic selected_condition_o,
  input wire logic flag_adjust_enable_o,
  input wire logic [5:0] flags_o,
  // bus
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  logic wr_q, en_q, take, quiet, loc, ovf_clr;
  logic [2:0] li;
  logic [3:0] s, ad;
  // tracks the step enable and clear bit written over the bus
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wr_q <= 1'b0;
      en_q <= 1'b1;
    end else begin
      wr_q <= hsel_i && hready_i && htrans_i[1] && hwrite_i && hsize_i == 3'h2 && haddr_i[7:0] == 8'h00;
      if (wr_q) begin
        en_q <= hwdata_i[0];
      end
    end
  end
  always_comb begin
    s = condition_select_field_i;
    take = step_i && en_q;
    quiet = !system_clear_i && !(wr_q && hwdata_i[1]);
    loc = s == 4'h2 || s == 4'h3 || s == 4'hd;
    li = (s == 4'hd) ? 3'h4 : s[2:0];
    ad = {adder_carry_out_i, adder_all_ones_i, adder_bottom_bit_i, adder_top_bit_i};
    ovf_clr = (take && s == 4'h8 && !nanobit48_i) || counter_load_i;
  end
  sequence s_ovf_test;
    take && s == 4'h8;
  endsequence
  a_adder_pick: assert property (take && s[3:2] == 2'b01 |=> selected_condition_o == $past(ad[s[1:0]]))
    else $error("adder condition wrong");
  a_succ_polarity: assert property (take |=> successor_select_o == (selected_condition_o == $past(test_polarity_bit_i)))
    else $error("successor wrong");
  a_mem_lines_low: assert property (take && (s == 4'h9 || s == 4'ha) |=> !selected_condition_o)
    else $error("memory line not asserted");
  a_adjust_gate: assert property (take |=> flag_adjust_enable_o == (!$past(conditional_side_effect_bit_i) || successor_select_o))
    else $error("adjust enable wrong");
  a_global_keep: assert property (take && s[3:1] == 3'h0 && flag_adjust_field_i == 3'h0 && quiet
    |=> flags_o[$past(s[0])] == $past(flags_o[s[0]]))
    else $error("global flag changed by test");
  a_local_clear: assert property (take && loc && flag_adjust_field_i == 3'h0 && quiet
    |=> !flags_o[$past(li)] && selected_condition_o == $past(flags_o[li]))
    else $error("local flag not cleared");
  a_set_wins: assert property (take && s == 4'h3 && flag_adjust_field_i == 3'h1 && !conditional_side_effect_bit_i && quiet
    |=> flags_o[3])
    else $error("set lost to test");
  a_ovf_clear: assert property (ovf_clr |=> !flags_o[5])
    else $error("overflow not cleared");
  a_ovf_set: assert property (counter_increment_i && counter_all_ones_i && !ovf_clr && !system_clear_i |=> flags_o[5])
    else $error("overflow not set");
  a_ovf_or: assert property (s_ovf_test |=> selected_condition_o == ($past(flags_o[5]) || $past(counter_live_overflow_i)))
    else $error("overflow test wrong");
  a_sys_clear: assert property (system_clear_i |=> flags_o == 6'h00)
    else $error("flags not cleared");
endmodule

// ---- test/port_selector_model.sv ----
// far side model: port selector and timer request lines
`timescale 1ns/1ps
module port_selector_model (
  // port interrupts and selection
  input wire logic [3:0] stat_irq_i,
  input wire logic [3:0] data_irq_i,
  input wire logic [1:0] sel_port_i,
  input wire logic timer_hit_i,
  // request lines, active low
  output logic any_req_n_o,
  output logic timer_n_o,
  output logic data_req_n_o,
  output logic stat_req_n_o
);
  logic [3:0] others;
  always_comb begin
    others = ~(4'h1 << sel_port_i);
    any_req_n_o = ~|((stat_irq_i | data_irq_i) & others);
    timer_n_o = ~timer_hit_i;
    data_req_n_o = ~data_irq_i[sel_port_i];
    stat_req_n_o = ~stat_irq_i[sel_port_i];
  end
endmodule

// ---- test/cond_register_tb_top.sv ----
// self-checking bench for the condition register
`timescale 1ns/1ps
module cond_register_tb_top;
  logic clk_i, reset_i, system_clear_i, step_i, pol, side, nb48, inc, ones, live, load, tm;
  logic hsel_i, hwrite_i, hreadyout_o, hresp_o, succ, cond, adj_en, any_n, tim_n, dat_n, sta_n;
  logic [3:0] sel, ad, st, dt;
  logic [2:0] adj, hsize_i;
  logic [1:0] sp, htrans_i;
  logic [31:0] haddr_i, hwdata_i, hrdata_o, rd;
  logic [5:0] flags;
  int mismatches, cmp_count, cycles;
  logic [2:0] acode [7] = '{3'h6, 3'h2, 3'h7, 3'h1, 3'h4, 3'h5, 3'h3};
  logic [5:0] aexp [7] = '{6'h01, 6'h03, 6'h07, 6'h0f, 6'h1f, 6'h1e, 6'h1c};
  logic [3:0] lsel [3] = '{4'h2, 4'h3, 4'hd};
  logic [5:0] lexp [3] = '{6'h19, 6'h11, 6'h01};

  cond_register i_dut (
    .clk_i(clk_i), .reset_i(reset_i), .system_clear_i(system_clear_i), .step_i(step_i),
    .condition_select_field_i(sel), .test_polarity_bit_i(pol), .conditional_side_effect_bit_i(side),
    .flag_adjust_field_i(adj), .nanobit48_i(nb48), .counter_increment_i(inc), .counter_all_ones_i(ones),
    .counter_live_overflow_i(live), .counter_load_i(load), .any_port_request_n_i(any_n),
    .timer_tick_interrupt_n_i(tim_n), .selected_port_data_request_n_i(dat_n),
    .selected_port_status_request_n_i(sta_n), .adder_top_bit_i(ad[0]), .adder_bottom_bit_i(ad[1]),
    .adder_all_ones_i(ad[2]), .adder_carry_out_i(ad[3]), .successor_select_o(succ),
    .selected_condition_o(cond), .flag_adjust_enable_o(adj_en), .flags_o(flags), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o)
  );
  port_selector_model i_ps (
    .stat_irq_i(st), .data_irq_i(dt), .sel_port_i(sp), .timer_hit_i(tm),
    .any_req_n_o(any_n), .timer_n_o(tim_n), .data_req_n_o(dat_n), .stat_req_n_o(sta_n)
  );

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic report_and_stop;
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      report_and_stop;
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      mismatches++;
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= {24'h0, a};
    hwrite_i <= w;
    hsize_i <= cond_pkg::HSIZE_WORD;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
  endtask

  // one microinstruction step, ends at the following falling edge
  task automatic stp(input logic [3:0] s, input logic p, input logic e, input logic [2:0] a);
    @(posedge clk_i);
    step_i <= 1'b1;
    sel <= s;
    pol <= p;
    side <= e;
    adj <= a;
    @(posedge clk_i);
    step_i <= 1'b0;
    @(negedge clk_i);
  endtask

  task automatic req_test(input logic [3:0] s, input logic [3:0] a, input logic [3:0] b, input logic t, input logic e);
    @(posedge clk_i);
    st <= a;
    dt <= b;
    tm <= t;
    stp(s, 1'b0, 1'b0, 3'h0);
    chk("line cond", {31'h0, e}, {31'h0, cond});
    chk("line succ", {31'h0, ~e}, {31'h0, succ});
  endtask

  initial begin
    {system_clear_i, step_i, sel, pol, side, adj, nb48, inc, ones, live, load, ad, st, dt, sp, tm} = '0;
    {hsel_i, hwrite_i, htrans_i, hsize_i, haddr_i, hwdata_i} = '0;
    reset_i = 1'b1;
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    bus(1'b0, 8'h00, 32'h0);
    chk("ctrl", 32'h1, rd);
    bus(1'b0, 8'h04, 32'h0);
    chk("status", 32'h0, rd);
    bus(1'b0, 8'h08, 32'h0);
    chk("unmapped", 32'h0, rd);
    chk("resp", 32'h0, {31'h0, hresp_o});
    foreach (acode[i]) begin
      stp(4'h4, 1'b1, 1'b0, acode[i]);
      chk("adjust", {26'h0, aexp[i]}, {26'h0, flags});
    end
    stp(4'h4, 1'b1, 1'b0, 3'h6);
    stp(4'h0, 1'b1, 1'b0, 3'h0);
    chk("global kept", 32'h1d, {26'h0, flags});
    chk("global succ", 32'h1, {31'h0, succ});
    foreach (lsel[i]) begin
      stp(lsel[i], 1'b1, 1'b0, 3'h0);
      chk("local clear", {26'h0, lexp[i]}, {26'h0, flags});
      chk("local succ", 32'h1, {31'h0, succ});
    end
    stp(4'h2, 1'b0, 1'b0, 3'h0);
    chk("false test", 32'h1, {31'h0, succ});
    stp(4'h3, 1'b1, 1'b0, 3'h1);
    chk("set wins", 32'h09, {26'h0, flags});
    stp(4'h4, 1'b1, 1'b1, 3'h5);
    chk("gated adjust", 32'h09, {26'h0, flags});
    chk("adjust off", 32'h0, {31'h0, adj_en});
    stp(4'h4, 1'b0, 1'b1, 3'h5);
    chk("enabled adjust", 32'h08, {26'h0, flags});
    @(posedge clk_i);
    ad <= 4'ha;
    for (int i = 0; i < 4; i++) begin
      stp(4'h4 + 4'(i), 1'b1, 1'b0, 3'h0);
      chk("adder", {28'h0, 4'ha >> i & 4'h1}, {31'h0, cond});
    end
    @(posedge clk_i);
    inc <= 1'b1;
    ones <= 1'b1;
    @(posedge clk_i);
    inc <= 1'b0;
    @(negedge clk_i);
    chk("ovf set", 32'h28, {26'h0, flags});
    @(posedge clk_i);
    inc <= 1'b1;
    stp(4'h8, 1'b1, 1'b0, 3'h0);
    chk("clear wins", 32'h08, {26'h0, flags});
    chk("ovf cond", 32'h1, {31'h0, cond});
    @(posedge clk_i);
    inc <= 1'b0;
    nb48 <= 1'b1;
    stp(4'h8, 1'b1, 1'b0, 3'h0);
    chk("gate held", 32'h28, {26'h0, flags});
    @(posedge clk_i);
    load <= 1'b1;
    @(posedge clk_i);
    load <= 1'b0;
    @(negedge clk_i);
    chk("load clear", 32'h08, {26'h0, flags});
    @(posedge clk_i);
    live <= 1'b1;
    nb48 <= 1'b0;
    stp(4'h8, 1'b1, 1'b0, 3'h0);
    chk("live ovf", 32'h1, {31'h0, succ});
    req_test(4'h9, 4'h0, 4'h0, 1'b0, 1'b0);
    req_test(4'ha, 4'h0, 4'h0, 1'b0, 1'b0);
    req_test(4'hb, 4'h4, 4'h0, 1'b0, 1'b0);
    req_test(4'hb, 4'h1, 4'h0, 1'b0, 1'b1);
    req_test(4'hc, 4'h0, 4'h0, 1'b1, 1'b0);
    req_test(4'hc, 4'h0, 4'h0, 1'b0, 1'b1);
    req_test(4'he, 4'h0, 4'h1, 1'b0, 1'b0);
    req_test(4'hf, 4'h1, 4'h0, 1'b0, 1'b0);
    req_test(4'hf, 4'h0, 4'h1, 1'b0, 1'b1);
    @(posedge clk_i);
    sp <= 2'h2;
    req_test(4'hb, 4'h4, 4'h0, 1'b0, 1'b1);
    req_test(4'he, 4'h0, 4'h4, 1'b0, 1'b0);
    bus(1'b1, 8'h00, 32'h0);
    stp(4'h4, 1'b1, 1'b0, 3'h7);
    chk("step refused", 32'h08, {26'h0, flags});
    bus(1'b1, 8'h00, 32'h3);
    bus(1'b0, 8'h00, 32'h0);
    chk("ctrl back", 32'h1, rd);
    chk("sw clear", 32'h0, {26'h0, flags});
    stp(4'h4, 1'b1, 1'b0, 3'h6);
    @(posedge clk_i);
    system_clear_i <= 1'b1;
    @(posedge clk_i);
    system_clear_i <= 1'b0;
    @(negedge clk_i);
    chk("sys clear", 32'h0, {26'h0, flags});
    report_and_stop;
  end
endmodule

bind cond_register cond_register_monitor i_mon (.*);
